// *** adcrc_pkg.sv ***
// package with register map, field layout and timing counts for the converter control
// Function
// - one conversion per completed start high-low pulse
// - busy set on launch, cleared on finish
// - enable bit powers converter, zero switches off
// - disabled converter leaves result registers unchanged
// - format zero: D11..4 high, D3..0 low-upper
// - format one: D11..8 high-lower, D7..0 low
// - unused result bit positions read zero
// - result pair read-only, holds twelve bits
// - channel codes 0..7 route analog input 0..7
// - channel codes 8..15 select nothing, floating
// - source 000, 101..111 select external path
// - source 001 bandgap, 010..100 ground
// - reference 01 analog supply, else reference pin
// - conversion clock is system clock over 2^field
// - analog input pin loses function and pull-high
// - completion raises converter interrupt request
package adcrc_pkg;
  localparam logic [7:0] ADCRC_OFS_RES_HI = 8'h00;
  localparam logic [7:0] ADCRC_OFS_RES_LO = 8'h04;
  localparam logic [7:0] ADCRC_OFS_CTRL0 = 8'h08;
  localparam logic [7:0] ADCRC_OFS_CTRL1 = 8'h0c;
  localparam logic [7:0] ADCRC_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADCRC_OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] ADCRC_OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADCRC_OFS_PIN_ANA = 8'h1c;
  localparam logic [7:0] ADCRC_CTRL0_RST = 8'h00;
  localparam logic [7:0] ADCRC_CTRL1_RST = 8'h00;
  localparam int ADCRC_C0_START = 7;
  localparam int ADCRC_C0_BUSY = 6;
  localparam int ADCRC_C0_EN = 5;
  localparam int ADCRC_C0_FMT = 4;
  localparam int ADCRC_C1_SRC_LSB = 5;
  localparam int ADCRC_C1_REF_LSB = 3;
  localparam int ADCRC_C1_CLK_LSB = 0;
  localparam logic [2:0] ADCRC_SRC_BANDGAP = 3'h1;
  localparam logic [2:0] ADCRC_SRC_GND_LO = 3'h2;
  localparam logic [2:0] ADCRC_SRC_GND_HI = 3'h4;
  localparam logic [1:0] ADCRC_REF_SUPPLY = 2'h1;
  localparam int ADCRC_RES_W = 12;
  localparam int ADCRC_NUM_CH = 8;
  // conversion takes this many converter clock ticks
  localparam logic [4:0] ADCRC_CONV_TICKS = 5'h10;
  typedef enum logic [1:0] {
    ADCRC_IDLE = 2'b00,
    ADCRC_CONV = 2'b01,
    ADCRC_DONE = 2'b10
  } adcrc_state_t;
endpackage

// *** adcrc_clkdiv.sv ***
// divider giving a one-cycle converter clock enable at pclk / 2^sel
`timescale 1ns/1ps
module adcrc_clkdiv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  import adcrc_pkg::*;
  logic [6:0] cnt_q;
  logic [6:0] limit;
  assign limit = 7'((8'h01 << sel) - 8'h01);
  assign tick = run && (cnt_q >= limit);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
    end else if (!run || tick) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
endmodule

// *** adcrc_sar.sv ***
// stand-in converter core: counts converter clock ticks, then captures the whole selected level at once on the last one
`timescale 1ns/1ps
module adcrc_sar (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic launch,
  input wire logic tick,
  input wire logic [11:0] sample,
  output logic [11:0] value,
  output logic finish
);
  import adcrc_pkg::*;
  logic [4:0] cnt_q;
  logic [11:0] val_q;
  logic active_q;
  assign value = val_q;
  assign finish = active_q && tick && (cnt_q == ADCRC_CONV_TICKS - 5'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      val_q <= 12'h000;
      active_q <= 1'b0;
    end else if (launch) begin
      cnt_q <= 5'h00;
      active_q <= 1'b1;
    end else if (finish) begin
      active_q <= 1'b0;
      val_q <= sample;
    end else if (active_q && tick) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule

// *** adcrc_top.sv ***
// converter register control with apb slave, interrupt and analog routing outputs
`timescale 1ns/1ps
module adcrc_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  ext_level,
  bandgap_level,
  irq,
  converter_power,
  analog_inputs,
  ext_floating,
  src_external,
  src_bandgap,
  src_ground,
  ref_from_supply,
  ref_from_pin,
  pin_analog_mode,
  pin_pullhigh_off
);
  import adcrc_pkg::*;
  input wire logic pclk;
  input wire logic presetn;
  input wire logic psel;
  input wire logic penable;
  input wire logic pwrite;
  input wire logic [7:0] paddr;
  input wire logic [31:0] pwdata;
  output logic [31:0] prdata;
  output logic pready;
  output logic pslverr;
  input wire logic [11:0] ext_level;
  input wire logic [11:0] bandgap_level;
  output logic irq;
  output logic converter_power;
  output logic [7:0] analog_inputs;
  output logic ext_floating;
  output logic src_external;
  output logic src_bandgap;
  output logic src_ground;
  output logic ref_from_supply;
  output logic ref_from_pin;
  output logic [7:0] pin_analog_mode;
  output logic [7:0] pin_pullhigh_off;

  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] pin_ana_q;
  logic [11:0] result_q;
  logic irq_stat_q;
  logic irq_en_q;
  logic [31:0] rdata_q;
  adcrc_state_t state_q;
  adcrc_state_t state_d;

  // apb decode: single-cycle answer, zero wait states
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_hi = paddr == ADCRC_OFS_RES_HI;
  wire hit_lo = paddr == ADCRC_OFS_RES_LO;
  wire hit_c0 = paddr == ADCRC_OFS_CTRL0;
  wire hit_c1 = paddr == ADCRC_OFS_CTRL1;
  wire hit_st = paddr == ADCRC_OFS_IRQ_STAT;
  wire hit_en = paddr == ADCRC_OFS_IRQ_EN;
  wire hit_clr = paddr == ADCRC_OFS_IRQ_CLR;
  wire hit_pin = paddr == ADCRC_OFS_PIN_ANA;
  wire mapped = hit_hi | hit_lo | hit_c0 | hit_c1 | hit_st | hit_en | hit_clr | hit_pin;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // field views
  wire enable = ctrl0_q[ADCRC_C0_EN];
  wire fmt = ctrl0_q[ADCRC_C0_FMT];
  wire start_bit = ctrl0_q[ADCRC_C0_START];
  wire [3:0] chan = ctrl0_q[3:0];
  wire [2:0] src = ctrl1_q[ADCRC_C1_SRC_LSB +: 3];
  wire [1:0] refsel = ctrl1_q[ADCRC_C1_REF_LSB +: 2];
  wire [2:0] clk_sel = ctrl1_q[ADCRC_C1_CLK_LSB +: 3];
  wire busy = state_q != ADCRC_IDLE;

  // start pulse completes when a write drops a set start bit
  wire start_fall = wr && hit_c0 && start_bit && !pwdata[ADCRC_C0_START];
  wire launch = start_fall && enable && pwdata[ADCRC_C0_EN] && !busy;

  // routing of analog source and reference
  assign converter_power = enable;
  assign src_bandgap = src == ADCRC_SRC_BANDGAP;
  assign src_ground = (src >= ADCRC_SRC_GND_LO) && (src <= ADCRC_SRC_GND_HI);
  assign src_external = !src_bandgap && !src_ground;
  assign ext_floating = chan[3];
  assign ref_from_supply = refsel == ADCRC_REF_SUPPLY;
  assign ref_from_pin = !ref_from_supply;
  assign pin_analog_mode = pin_ana_q;
  assign pin_pullhigh_off = pin_ana_q;

  genvar gi;
  generate
    for (gi = 0; gi < ADCRC_NUM_CH; gi++) begin : g_route
      // internal source never shorted: pin only drives when external path chosen
      assign analog_inputs[gi] = src_external && !chan[3] && (chan[2:0] == gi);
    end
  endgenerate

  wire [11:0] sample = src_bandgap ? bandgap_level : (src_ground || ext_floating) ? 12'h000
                       : ext_level;

  logic tick;
  logic finish;
  logic [11:0] conv_value;

  adcrc_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(busy && enable),
    .sel(clk_sel),
    .tick(tick)
  );

  adcrc_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .launch(launch),
    .tick(tick),
    .sample(sample),
    .value(conv_value),
    .finish(finish)
  );

  // busy state machine; disabling mid conversion aborts without a result
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ADCRC_IDLE: begin
        if (launch) begin
          state_d = ADCRC_CONV;
        end
      end
      ADCRC_CONV: begin
        if (!enable) begin
          state_d = ADCRC_IDLE;
        end else if (finish) begin
          state_d = ADCRC_DONE;
        end
      end
      ADCRC_DONE: begin
        state_d = ADCRC_IDLE;
      end
      default: begin
        state_d = ADCRC_IDLE;
      end
    endcase
  end

  wire done = state_q == ADCRC_DONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ADCRC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // result copied in the done cycle, once the core has latched it, landing with the busy drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 12'h000;
    end else if (done && enable) begin
      result_q <= conv_value;
    end
  end

  // control registers; busy bit is read-only and never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= ADCRC_CTRL0_RST;
      ctrl1_q <= ADCRC_CTRL1_RST;
      pin_ana_q <= 8'h00;
      irq_en_q <= 1'b0;
    end else if (wr) begin
      if (hit_c0) begin
        ctrl0_q <= pwdata[7:0] & 8'hbf;
      end
      if (hit_c1) begin
        ctrl1_q <= pwdata[7:0];
      end
      if (hit_pin) begin
        pin_ana_q <= pwdata[7:0];
      end
      if (hit_en) begin
        irq_en_q <= pwdata[0];
      end
    end
  end

  // sticky completion flag, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 1'b0;
    end else if (done) begin
      irq_stat_q <= 1'b1;
    end else if (wr && hit_clr && pwdata[0]) begin
      irq_stat_q <= 1'b0;
    end
  end
  assign irq = irq_stat_q && irq_en_q;

  // result views per format; unused positions are zero
  wire [7:0] res_hi = fmt ? {4'h0, result_q[11:8]} : result_q[11:4];
  wire [7:0] res_lo = fmt ? result_q[7:0] : {result_q[3:0], 4'h0};
  wire [7:0] c0_view = {ctrl0_q[7], busy, ctrl0_q[5:0]};
  wire [7:0] rsel = hit_hi ? res_hi : hit_lo ? res_lo : hit_c0 ? c0_view : hit_c1 ? ctrl1_q
                  : hit_st ? {7'h00, irq_stat_q} : hit_en ? {7'h00, irq_en_q}
                  : hit_pin ? pin_ana_q : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= {24'h00_0000, rsel};
    end
  end
  assign prdata = rd ? rdata_q : 32'h0000_0000;

  // checks
  AST_LAUNCH_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    launch |=> busy) else $error("busy not set after launch");
  AST_NO_LAUNCH_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy && !enable) |=> !busy) else $error("conversion started while disabled");
  AST_BUSY_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> !busy) else $error("busy not cleared after finish");
  AST_RESULT_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> $stable(result_q)) else $error("result changed while disabled");
  AST_RESULT_BEFORE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ADCRC_CONV && finish && enable) ##1 enable
    |=> (!busy && result_q == $past(sample, 2)))
    else $error("result not written before busy cleared");
  AST_FMT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    !fmt |-> (res_lo[3:0] == 4'h0 && {res_hi, res_lo[7:4]} == result_q))
    else $error("left format wrong");
  AST_FMT_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    fmt |-> (res_hi[7:4] == 4'h0 && {res_hi[3:0], res_lo} == result_q))
    else $error("right format wrong");
  AST_IRQ_ON_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    done ##1 irq_en_q |-> irq) else $error("interrupt missing after finish");
  AST_ROUTE_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(analog_inputs) && ((src_external && !chan[3]) || analog_inputs == 8'h00))
    else $error("bad channel routing");
  AST_SRC_EXCL: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot({src_external, src_bandgap, src_ground})) else $error("source not unique");
  AST_CLK_DIV: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && clk_sel == 3'h1 && busy && enable) |=> !tick) else $error("divide ratio wrong");
  AST_REF: assert property (@(posedge pclk) disable iff (!presetn)
    ref_from_pin == (refsel != ADCRC_REF_SUPPLY)) else $error("reference select wrong");
endmodule

// *** adc_register_control_bench.sv ***
// self-checking bench for the converter register control
`timescale 1ns/1ps
module adc_register_control_bench;
  import adcrc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, converter_power, fmt, err;
  logic ext_floating, src_external, src_bandgap, src_ground, ref_from_supply, ref_from_pin;
  logic [7:0] paddr, analog_inputs, pin_analog_mode, pin_pullhigh_off;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] ext_level, bandgap_level, v;
  logic [3:0] ch;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed, t0, sel;

  adcrc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_level(ext_level), .bandgap_level(bandgap_level), .irq(irq),
    .converter_power(converter_power), .analog_inputs(analog_inputs),
    .ext_floating(ext_floating), .src_external(src_external), .src_bandgap(src_bandgap),
    .src_ground(src_ground), .ref_from_supply(ref_from_supply), .ref_from_pin(ref_from_pin),
    .pin_analog_mode(pin_analog_mode), .pin_pullhigh_off(pin_pullhigh_off));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) cyc <= cyc + 1;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one idle cycle after each transfer keeps psel from being assigned twice in one step
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] res_hi(input logic [11:0] x, input logic f);
    return f ? 32'(x[11:8]) : 32'(x[11:4]);
  endfunction

  function automatic logic [31:0] res_lo(input logic [11:0] x, input logic f);
    return f ? 32'(x[7:0]) : 32'({x[3:0], 4'h0});
  endfunction

  task stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // the whole run needs a few thousand cycles
  initial begin
    #300000;
    error_cnt++;
    stop_test;
  end

  initial begin
    seed = 36465;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_level = 12'h000;
    bandgap_level = 12'h000;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(src_external, 1);
    chk(ref_from_pin, 1);
    chk(converter_power, 0);
    bus(0, ADCRC_OFS_CTRL0, 0); chk(rd, 32'(ADCRC_CTRL0_RST));
    bus(0, ADCRC_OFS_CTRL1, 0); chk(rd, 32'(ADCRC_CTRL1_RST));
    bus(0, 8'h20, 0); chk({err, rd[30:0]}, 32'h8000_0000);
    bus(1, ADCRC_OFS_RES_HI, 32'hffff_ffff);
    bus(0, ADCRC_OFS_RES_HI, 0); chk(rd, 0);
    bus(1, ADCRC_OFS_PIN_ANA, 8'h5a);
    chk({pin_analog_mode, pin_pullhigh_off}, 16'h5a5a);
    // internal sources always get a missing channel, parked on one while the source changes
    for (int k = 0; k < 32; k++) begin
      ch = 4'($random(seed));
      if (k[2:0] inside {[1:4]}) ch[3] = 1'b1;
      bus(1, ADCRC_OFS_CTRL0, 8'h08);
      bus(1, ADCRC_OFS_CTRL1, {k[2:0], k[4:3], 3'h0});
      bus(1, ADCRC_OFS_CTRL0, {4'h0, ch});
      chk(src_external, k[2:0] == 0 || k[2:0] >= 5);
      chk({src_bandgap, src_ground}, {k[2:0] == 1, k[2:0] inside {[2:4]}});
      chk(ext_floating, ch[3]);
      chk(analog_inputs, !ch[3] ? 8'h01 << ch[2:0] : 8'h00);
      chk({ref_from_supply, ref_from_pin}, {k[4:3] == 1, k[4:3] != 1});
    end
    // odd passes use right-justified format, pass i divides by 2^i, the fourth converts the bandgap
    for (int i = 0; i < 8; i++) begin
      fmt = i[0];
      sel = i;
      ch = (i == 3) ? 4'h8 : 4'h2;
      v = (i == 0) ? 12'hfff : 12'($random(seed));
      if (i == 3) bandgap_level <= v;
      else ext_level <= v;
      bus(1, ADCRC_OFS_IRQ_EN, i != 2);
      bus(1, ADCRC_OFS_CTRL0, {3'h1, fmt, 4'h8});
      bus(1, ADCRC_OFS_CTRL1, {(i == 3) ? 3'h1 : 3'h0, 2'h0, 3'(sel)});
      chk(converter_power, 1);
      bus(1, ADCRC_OFS_CTRL0, {3'h5, fmt, ch});
      bus(0, ADCRC_OFS_CTRL0, 0); chk(rd[6], 0);
      bus(1, ADCRC_OFS_CTRL0, {3'h1, fmt, ch});
      t0 = cyc;
      bus(0, ADCRC_OFS_CTRL0, 0); chk(rd[6], 1);
      for (int n = 0; n < 1000 && rd[6] === 1'b1; n++) bus(0, ADCRC_OFS_CTRL0, 0);
      chk(rd[6], 0);
      chk(cyc - t0 >= (16 << sel) - 2 && cyc - t0 <= (17 << sel) + 24, 1);
      chk(irq, i != 2);
      bus(0, ADCRC_OFS_IRQ_STAT, 0); chk(rd, 1);
      bus(1, ADCRC_OFS_IRQ_EN, 1); chk(irq, 1);
      bus(1, ADCRC_OFS_IRQ_CLR, 1); chk(irq, 0);
      bus(0, ADCRC_OFS_RES_HI, 0); chk(rd, res_hi(v, fmt));
      bus(0, ADCRC_OFS_RES_LO, 0); chk(rd, res_lo(v, fmt));
    end
    // switching off mid conversion aborts it; a start while off is ignored; results stay
    ext_level <= ~v;
    bus(1, ADCRC_OFS_CTRL0, 8'ha2);
    bus(1, ADCRC_OFS_CTRL0, 8'h22);
    bus(0, ADCRC_OFS_CTRL0, 0); chk(rd[6], 1);
    bus(1, ADCRC_OFS_CTRL0, 8'h02);
    chk(converter_power, 0);
    bus(1, ADCRC_OFS_CTRL0, 8'h82);
    bus(1, ADCRC_OFS_CTRL0, 8'h02);
    bus(0, ADCRC_OFS_CTRL0, 0); chk(rd[6], 0);
    bus(0, ADCRC_OFS_RES_HI, 0); chk(rd, res_hi(v, 0));
    bus(0, ADCRC_OFS_RES_LO, 0); chk(rd, res_lo(v, 0));
    bus(0, ADCRC_OFS_IRQ_STAT, 0); chk(rd, 0);
    stop_test;
  end
endmodule
